//--- core/jtag_probe_ctrl.sv
/*
 file: tap controller, shared test-pin mode switch and net probe routing.
 assumes: test pins arrive asynchronously and are sampled on clock; tck is
 far slower than clock; configuration inputs are static while running.
*/
`timescale 1ns/1ps
`include "jtag_probe_params.svh"

module jtag_probe_ctrl
   import jtag_probe_pkg::*;
(
   input  wire logic                        clock,
   input  wire logic                        arst_n,
   input  wire static_cfg_t                 cfg,
   input  wire test_pins_t                  pins_in,
   input  wire logic [`PROBE_NET_COUNT-1:0] probe_nets,
   input  wire logic                        user_tdo_out,
   input  wire logic                        user_tdo_oe,
   input  wire logic                        user_pra_out,
   input  wire logic                        user_pra_oe,
   input  wire logic                        user_prb_out,
   input  wire logic                        user_prb_oe,
   output logic                             tdo_out,
   output logic                             tdo_oe,
   output logic                             probe_out_a,
   output logic                             probe_out_a_oe,
   output logic                             probe_out_b,
   output logic                             probe_out_b_oe,
   output logic                             user_tdi_in,
   output logic                             user_tck_in,
   output logic                             user_in_valid,
   output logic                             scan_test_function,
   output logic                             probe_active
);

   test_pins_t            s1_reg, s2_reg, s3_reg, pin_reg, pin_next;
   static_cfg_t           cfg_reg;
   logic                  tck_prev_reg;
   logic                  tck_rise, tck_fall;
   logic                  trst_eff;
   tap_state_t            tap_reg, tap_next;
   logic [2:0]            tms_cnt_reg, tms_cnt_next;
   logic                  func_reg, func_next;
   logic [`IR_WIDTH-1:0]  ir_sh_reg, ir_sh_next, ir_reg, ir_next;
   logic [`PROBE_CMD_WIDTH-1:0] dr_sh_reg, dr_sh_next;
   probe_sel_t            sel_reg, sel_next;
   logic                  tdo_bit_reg, tdo_bit_next;
   logic                  probe_on;

   // three-stage sampling; a change counts when stages two and three agree
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg       <= test_pins_t'(`PIN_RESET_VALUE);
         s2_reg       <= test_pins_t'(`PIN_RESET_VALUE);
         s3_reg       <= test_pins_t'(`PIN_RESET_VALUE);
         pin_reg      <= test_pins_t'(`PIN_RESET_VALUE);
         cfg_reg      <= static_cfg_t'(`SYNC_RESET_VALUE);
         tck_prev_reg <= 1'b0;
      end else begin
         s1_reg       <= pins_in;
         s2_reg       <= s1_reg;
         s3_reg       <= s2_reg;
         pin_reg      <= pin_next;
         cfg_reg      <= cfg;
         tck_prev_reg <= pin_reg.tck;
      end
   end

   always_comb begin
      pin_next = pin_reg;
      for (int i = 0; i < $bits(test_pins_t); i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            pin_next[i] = s3_reg[i];
         end
      end
   end

   assign tck_rise = pin_reg.tck & ~tck_prev_reg;
   assign tck_fall = ~pin_reg.tck & tck_prev_reg;
   assign trst_eff = cfg_reg.trst_reserved ? pin_reg.trst_n : 1'b1;

   // tap state machine, release counter and pin-function flag
   always_comb begin
      tap_next     = tap_reg;
      tms_cnt_next = tms_cnt_reg;
      func_next    = func_reg;
      if (!trst_eff) begin
         tap_next     = TAP_RESET;
         tms_cnt_next = 3'h0;
         func_next    = 1'b0;
      end else if (tck_rise) begin
         case (tap_reg)
            TAP_RESET:      tap_next = pin_reg.tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE:       tap_next = pin_reg.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR:     tap_next = pin_reg.tms ? TAP_SEL_IR : TAP_CAPTURE_DR;
            TAP_CAPTURE_DR: tap_next = pin_reg.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR:   tap_next = pin_reg.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR:   tap_next = pin_reg.tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR:   tap_next = pin_reg.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR:   tap_next = pin_reg.tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
            TAP_UPDATE_DR:  tap_next = pin_reg.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR:     tap_next = pin_reg.tms ? TAP_RESET : TAP_CAPTURE_IR;
            TAP_CAPTURE_IR: tap_next = pin_reg.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR:   tap_next = pin_reg.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR:   tap_next = pin_reg.tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR:   tap_next = pin_reg.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR:   tap_next = pin_reg.tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
            TAP_UPDATE_IR:  tap_next = pin_reg.tms ? TAP_SEL_DR : TAP_IDLE;
            default:        tap_next = TAP_RESET;
         endcase
         if (pin_reg.tms) begin
            if (tms_cnt_reg != `TMS_RELEASE_COUNT) begin
               tms_cnt_next = tms_cnt_reg + 3'h1;
            end
         end else begin
            tms_cnt_next = 3'h0;
            func_next    = 1'b1;
         end
         if (pin_reg.tms && tms_cnt_reg == `TMS_RELEASE_COUNT - 3'h1) begin
            func_next = 1'b0;
         end
      end
   end

   // instruction and probe-select shift paths
   always_comb begin
      ir_sh_next   = ir_sh_reg;
      ir_next      = ir_reg;
      dr_sh_next   = dr_sh_reg;
      sel_next     = sel_reg;
      tdo_bit_next = tdo_bit_reg;
      if (tap_reg == TAP_RESET) begin
         ir_next = `IR_RESET_VALUE;
      end
      if (tck_rise) begin
         case (tap_reg)
            TAP_CAPTURE_IR: ir_sh_next = `IR_RESET_VALUE;
            TAP_SHIFT_IR:   ir_sh_next = {pin_reg.tdi, ir_sh_reg[`IR_WIDTH-1:1]};
            TAP_UPDATE_IR:  ir_next = ir_sh_reg;
            TAP_CAPTURE_DR: dr_sh_next = sel_reg;
            TAP_SHIFT_DR:   dr_sh_next = {pin_reg.tdi, dr_sh_reg[`PROBE_CMD_WIDTH-1:1]};
            TAP_UPDATE_DR: begin
               if (ir_reg == `IR_PROBE_SELECT) begin
                  sel_next = probe_sel_t'(dr_sh_reg);
               end
            end
            default: ;
         endcase
      end
      if (tck_fall) begin
         tdo_bit_next = (tap_reg == TAP_SHIFT_IR) ? ir_sh_reg[0] : dr_sh_reg[0];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tap_reg     <= TAP_RESET;
         tms_cnt_reg <= 3'h0;
         func_reg    <= 1'b0;
         ir_sh_reg   <= `IR_RESET_VALUE;
         ir_reg      <= `IR_RESET_VALUE;
         dr_sh_reg   <= '0;
         sel_reg     <= '0;
         tdo_bit_reg <= 1'b0;
      end else begin
         tap_reg     <= tap_next;
         tms_cnt_reg <= tms_cnt_next;
         func_reg    <= func_next;
         ir_sh_reg   <= ir_sh_next;
         ir_reg      <= ir_next;
         dr_sh_reg   <= dr_sh_next;
         sel_reg     <= sel_next;
         tdo_bit_reg <= tdo_bit_next;
      end
   end

   // dedicated mode keeps the pins as test pins at all times but the first clock after reset, while cfg_reg still reads zero
   logic test_fn;
   assign test_fn  = cfg_reg.dedicated_mode | func_reg;
   assign probe_on = test_fn & trst_eff & ~cfg_reg.fuse_programmed;

   // pin muxing; every output registered
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tdo_out            <= 1'b0;
         tdo_oe             <= 1'b0;
         probe_out_a        <= 1'b0;
         probe_out_a_oe     <= 1'b0;
         probe_out_b        <= 1'b0;
         probe_out_b_oe     <= 1'b0;
         user_tdi_in        <= 1'b0;
         user_tck_in        <= 1'b0;
         user_in_valid      <= 1'b0;
         scan_test_function <= 1'b0;
         probe_active       <= 1'b0;
      end else begin
         scan_test_function <= test_fn;
         probe_active       <= probe_on;
         tdo_out            <= test_fn ? tdo_bit_reg : user_tdo_out;
         tdo_oe             <= test_fn ? (tap_reg == TAP_SHIFT_DR ||
                                          tap_reg == TAP_SHIFT_IR) : user_tdo_oe;
         // probe pins fall back to user io whenever probing is off
         probe_out_a    <= probe_on ? probe_nets[sel_reg.sel_a] : user_pra_out;
         probe_out_a_oe <= probe_on ? 1'b1 : user_pra_oe;
         probe_out_b    <= probe_on ? probe_nets[sel_reg.sel_b] : user_prb_out;
         probe_out_b_oe <= probe_on ? 1'b1 : user_prb_oe;
         user_tdi_in    <= test_fn ? 1'b0 : pin_reg.tdi;
         user_tck_in    <= test_fn ? 1'b0 : pin_reg.tck;
         user_in_valid  <= ~test_fn;
      end
   end

   AST_TRST_HOLDS: assert property (@(posedge clock) disable iff (!arst_n)
      !trst_eff |=> tap_reg == TAP_RESET)
      else $error("tap left reset under test reset");
   AST_FUSE_NO_PROBE: assert property (@(posedge clock) disable iff (!arst_n)
      cfg_reg.fuse_programmed |=> !probe_active)
      else $error("probe active with fuse programmed");
   AST_PROBE_NEEDS_FN: assert property (@(posedge clock) disable iff (!arst_n)
      probe_active |-> $past(test_fn) && $past(trst_eff))
      else $error("probe active without test function");
   AST_TAKE_PINS: assert property (@(posedge clock) disable iff (!arst_n)
      tck_rise && !pin_reg.tms && trst_eff |=> func_reg)
      else $error("tms low did not take the pins");
   AST_RELEASE: assert property (@(posedge clock) disable iff (!arst_n)
      tck_rise && pin_reg.tms && trst_eff &&
      tms_cnt_reg == `TMS_RELEASE_COUNT - 3'h1 |=> !func_reg)
      else $error("pins not released after five tms high");
   // a drop of the pin-function flag needs test reset or the full run of tms high
   AST_NO_EARLY_RELEASE: assert property (@(posedge clock) disable iff (!arst_n)
      $fell(func_reg) |-> !$past(trst_eff) || tms_cnt_reg == `TMS_RELEASE_COUNT)
      else $error("pins released early");
   AST_DEDICATED: assert property (@(posedge clock) disable iff (!arst_n)
      cfg_reg.dedicated_mode |=> !user_in_valid)
      else $error("dedicated pins reached user logic");
   AST_USER_BLOCK: assert property (@(posedge clock) disable iff (!arst_n)
      probe_active |-> !user_in_valid && !user_tdi_in)
      else $error("user input passed while probing");
   AST_TRST_RESET_ROUTE: assert property (@(posedge clock) disable iff (!arst_n)
      !trst_eff && !cfg_reg.dedicated_mode ##1 1'b1 |=> user_in_valid)
      else $error("flexible pins not user io under test reset");

endmodule

//--- core/jtag_probe_params.svh
/*
 file: constants for the test-port pin mode and probe control block.
 assumes: included by the package and the design file only.
*/
`ifndef JTAG_PROBE_PARAMS_SVH
`define JTAG_PROBE_PARAMS_SVH

`define TMS_RELEASE_COUNT   3'h5
`define PROBE_SEL_WIDTH     8
`define PROBE_CMD_WIDTH     16
`define PROBE_NET_COUNT     256
`define IR_WIDTH            4
`define IR_RESET_VALUE      4'h1
`define IR_PROBE_SELECT     4'h7
`define SYNC_RESET_VALUE    3'h0
`define PIN_RESET_VALUE     4'h1

`endif

//--- core/jtag_probe_pkg.sv
/*
 file: types for the test-port pin mode and probe control block.
 assumes: compiled before the design file.
*/
`include "jtag_probe_params.svh"

package jtag_probe_pkg;

   typedef enum logic [3:0] {
      TAP_RESET      = 4'h0,
      TAP_IDLE       = 4'h1,
      TAP_SEL_DR     = 4'h2,
      TAP_CAPTURE_DR = 4'h3,
      TAP_SHIFT_DR   = 4'h4,
      TAP_EXIT1_DR   = 4'h5,
      TAP_PAUSE_DR   = 4'h6,
      TAP_EXIT2_DR   = 4'h7,
      TAP_UPDATE_DR  = 4'h8,
      TAP_SEL_IR     = 4'h9,
      TAP_CAPTURE_IR = 4'ha,
      TAP_SHIFT_IR   = 4'hb,
      TAP_EXIT1_IR   = 4'hc,
      TAP_PAUSE_IR   = 4'hd,
      TAP_EXIT2_IR   = 4'he,
      TAP_UPDATE_IR  = 4'hf
   } tap_state_t;

   typedef struct packed {
      logic dedicated_mode;
      logic trst_reserved;
      logic fuse_programmed;
   } static_cfg_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } test_pins_t;

   typedef struct packed {
      logic [`PROBE_SEL_WIDTH-1:0] sel_a;
      logic [`PROBE_SEL_WIDTH-1:0] sel_b;
   } probe_sel_t;

endpackage

//--- dv/jtag_probe_ctrl_bench.sv
/*
 file: self-checking bench for the test-pin mode switch and probe routing.
 assumes: the tester model drives the pins; the bench drives the rest at falling clock edges.
*/
`timescale 1ns/1ps

module jtag_probe_ctrl_bench;
   import jtag_probe_pkg::*;
   logic         clock = 1'b0;
   logic         arst_n = 1'b0;
   static_cfg_t  cfg = 3'h2;
   logic [255:0] probe_nets = 256'h0420;
   logic [5:0]   user_drv = 6'h2d;
   test_pins_t   pins;
   logic         tdo_out, tdo_oe, probe_out_a, probe_out_a_oe, probe_out_b, probe_out_b_oe;
   logic         user_tdi_in, user_tck_in, user_in_valid, scan_test_function, probe_active;
   int           failures = 0;
   int           total_checks = 0;

   always #2.5 clock = ~clock;

   jtag_tester_model tester (.clock(clock), .tdo(tdo_out), .pins(pins));

   jtag_probe_ctrl dut_u (
      .clock(clock), .arst_n(arst_n), .cfg(cfg), .pins_in(pins), .probe_nets(probe_nets),
      .user_tdo_out(user_drv[0]), .user_tdo_oe(user_drv[1]), .user_pra_out(user_drv[2]),
      .user_pra_oe(user_drv[3]), .user_prb_out(user_drv[4]), .user_prb_oe(user_drv[5]),
      .tdo_out(tdo_out), .tdo_oe(tdo_oe), .probe_out_a(probe_out_a),
      .probe_out_a_oe(probe_out_a_oe), .probe_out_b(probe_out_b),
      .probe_out_b_oe(probe_out_b_oe), .user_tdi_in(user_tdi_in), .user_tck_in(user_tck_in),
      .user_in_valid(user_in_valid), .scan_test_function(scan_test_function),
      .probe_active(probe_active));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic status(input logic [2:0] exp);
      check({scan_test_function, user_in_valid, probe_active}, exp);
   endtask

   // pin edges take about four clocks to be seen, so eight is a safe margin
   task automatic settle();
      repeat (8) @(negedge clock);
   endtask

   // configuration is only changed while reset holds, since it is static in use
   task automatic restart(input static_cfg_t c);
      arst_n = 1'b0;
      cfg    = c;
      repeat (20) @(negedge clock);
      arst_n = 1'b1;
      repeat (4) @(negedge clock);
   endtask

   task automatic set_trst(input logic v);
      tester.drive_trst(v);
      settle();
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      give_verdict();
   end

   initial begin
      @(negedge clock);
      restart(3'h2);
      tester.drive_tdi(1'b1);
      settle();
      status(3'h2);
      check({user_tdi_in, tdo_out, tdo_oe}, {1'b1, user_drv[0], user_drv[1]});
      // tms high never sets the pin-function flag, so tck must reach user logic mid-cycle
      fork
         tester.tck_cycle(1'b1, 1'b1);
         begin
            repeat (18) @(negedge clock);
            check({user_tck_in, user_in_valid}, 2'h3);
         end
      join
      $display("test user io after reset done");
      tester.tck_cycle(1'b0, 1'b1);
      settle();
      status(3'h5);
      check(user_tdi_in, 1'b0);
      $display("test take pins done");
      tester.tck_cycle(1'b1, 1'b0);
      tester.tck_cycle(1'b1, 1'b0);
      tester.tck_cycle(1'b0, 1'b0);
      tester.tck_cycle(1'b0, 1'b0);
      tester.shift_bits(4, 16'h0007);
      check(tester.tdo_bits[15:12], 4'h1);
      tester.tck_cycle(1'b1, 1'b0);
      tester.tck_cycle(1'b0, 1'b0);
      tester.tck_cycle(1'b1, 1'b0);
      tester.tck_cycle(1'b0, 1'b0);
      tester.tck_cycle(1'b0, 1'b0);
      tester.shift_bits(16, 16'h050a);
      tester.tck_cycle(1'b1, 1'b0);
      tester.tck_cycle(1'b0, 1'b0);
      settle();
      check({probe_out_a, probe_out_a_oe, probe_out_b, probe_out_b_oe}, 4'hf);
      probe_nets = ~probe_nets;
      settle();
      check({probe_out_a, probe_out_a_oe, probe_out_b, probe_out_b_oe}, 4'h5);
      $display("test net select done");
      set_trst(1'b0);
      status(3'h2);
      check({probe_out_a_oe, probe_out_a}, user_drv[3:2]);
      set_trst(1'b1);
      $display("test reset pin low done");
      tester.tck_cycle(1'b0, 1'b0);
      repeat (4) tester.tck_cycle(1'b1, 1'b0);
      settle();
      check(scan_test_function, 1'b1);
      tester.tck_cycle(1'b1, 1'b0);
      settle();
      status(3'h2);
      $display("test release pins done");
      restart(3'h3);
      // user drive all low, so a net leaking onto a probe pin shows as a one
      user_drv = 6'h00;
      tester.tck_cycle(1'b0, 1'b0);
      settle();
      check({probe_active, probe_out_a_oe, probe_out_b_oe}, 3'h0);
      check({probe_out_a, probe_out_b}, 2'h0);
      $display("test secured done");
      restart(3'h0);
      set_trst(1'b0);
      tester.tck_cycle(1'b0, 1'b0);
      settle();
      check(probe_active, 1'b1);
      set_trst(1'b1);
      $display("test unreserved reset done");
      restart(3'h6);
      check(user_in_valid, 1'b0);
      set_trst(1'b0);
      status(3'h4);
      set_trst(1'b1);
      tester.tck_cycle(1'b0, 1'b0);
      settle();
      check({scan_test_function, probe_active}, 2'h3);
      $display("test dedicated mode done");
      give_verdict();
   end
endmodule

//--- dv/jtag_tester_model.sv
/*
 file: behavioural test-port tester that drives tck, tms, tdi and test reset.
 assumes: every call starts just after a falling clock edge; tck rests low between frames.
*/
`timescale 1ns/1ps

module jtag_tester_model
   import jtag_probe_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  tdo,
   output test_pins_t pins
);
   logic [15:0] tdo_bits;

   initial begin
      pins     = 4'h5;
      tdo_bits = 16'h0000;
   end

   // static pin levels are only moved from here, so the pins have one writer
   task automatic drive_trst(input logic v);
      pins.trst_n = v;
   endtask

   task automatic drive_tdi(input logic v);
      pins.tdi = v;
   endtask

   // 12 clocks low and 13 high give the 125 ns tck period; tms and tdi move on tck fall
   task automatic tck_cycle(input logic tms_v, input logic tdi_v);
      pins.tms = tms_v;
      pins.tdi = tdi_v;
      repeat (12) @(negedge clock);
      pins.tck = 1'b1;
      tdo_bits = {tdo, tdo_bits[15:1]};
      repeat (13) @(negedge clock);
      pins.tck = 1'b0;
   endtask

   // lsb first, tms high on the last bit to leave the shift state
   task automatic shift_bits(input int n, input logic [15:0] v);
      for (int i = 0; i < n; i++) begin
         tck_cycle(i == n - 1, v[i]);
      end
   endtask
endmodule
